//--- logic/sssc_pkg.sv
package sssc_pkg;
   // apb word offsets (byte addresses)
   localparam logic [7:0] SSSC_PRI_CTRL_OFF = 8'h00;
   localparam logic [7:0] SSSC_SEC_CTRL_OFF = 8'h04;
   localparam logic [7:0] SSSC_PRI_STS_OFF = 8'h08;
   localparam logic [7:0] SSSC_SEC_STS_OFF = 8'h0C;
   localparam logic [7:0] SSSC_STATE_OFF = 8'h10;
   localparam logic [7:0] SSSC_DESC_S0_OFF = 8'h14;
   localparam logic [7:0] SSSC_DESC_S1_OFF = 8'h18;
   localparam logic [7:0] SSSC_DESC_S2_OFF = 8'h1C;
   localparam logic [7:0] SSSC_WAKE_EN_OFF = 8'h20;
   localparam logic [7:0] SSSC_IRQ_STS_OFF = 8'h24;
   localparam logic [7:0] SSSC_IRQ_EN_OFF = 8'h28;
   localparam logic [7:0] SSSC_IRQ_CLR_OFF = 8'h2C;
   // control register fields
   localparam int SSSC_TYPE_LSB = 10;
   localparam int SSSC_TYPE_W = 3;
   localparam int SSSC_ENABLE_BIT = 13;
   // status register field
   localparam int SSSC_WAKE_BIT = 15;
   // descriptor bytes: byte 0 primary code, byte 1 secondary code, bytes 2-3 reserved
   localparam int SSSC_DESC_PRI_LSB = 0;
   localparam int SSSC_DESC_SEC_LSB = 8;
   // sleep type codes carried by the firmware descriptors
   localparam logic [2:0] SSSC_CODE_S0 = 3'h0;
   localparam logic [2:0] SSSC_CODE_S1 = 3'h1;
   localparam logic [2:0] SSSC_CODE_S2 = 3'h2;
   // interrupt event bits
   localparam int SSSC_IRQ_ENTER_BIT = 0;
   localparam int SSSC_IRQ_WAKE_BIT = 1;
   localparam int SSSC_IRQ_W = 2;
   // entry/exit settle time
   localparam int SSSC_SETTLE_NS = 1000;
   localparam int SSSC_CLK_NS = 50;
   localparam int SSSC_SETTLE_CYC = (SSSC_SETTLE_NS + SSSC_CLK_NS - 1) / SSSC_CLK_NS;
   typedef enum logic [2:0] {
      SSSC_WORK = 3'b000,
      SSSC_ENTER = 3'b001,
      SSSC_SLEEP1 = 3'b010,
      SSSC_SLEEP2 = 3'b011,
      SSSC_EXIT = 3'b100
   } sssc_state_t;
endpackage : sssc_pkg

//--- logic/sssc_sync.sv
`timescale 1ns/1ps
module sssc_sync #(
   parameter int WIDTH = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;
   initial begin
      if (WIDTH < 1) $error("sssc_sync: WIDTH must be at least 1");
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end
   // a bit changes only once the last two stages agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge core_clk) begin
            if (rst) begin
               syncOut[i] <= 1'b0;
            end else if (stage2_reg[i] == stage3_reg[i]) begin
               syncOut[i] <= stage3_reg[i];
            end
         end
      end
   endgenerate
endmodule : sssc_sync

//--- logic/sssc_top.sv
`timescale 1ns/1ps
// Operation
// - four-byte descriptor per state, two codes
// - sleep only when software commands it
// - return to working happens in hardware
// - write one clears wake flag
// - shallow sleep keeps context, resumes in place
// - deep sleep wake restarts at boot
// - shallow sleep turns off working resources
// - deep sleep turns off working and shallow resources
// - enabled, wake-capable device event wakes the system
// - unpowered devices held in off state
// - memory kept in working and both sleeps
// - secondary enable bit starts sequence into primary programmed type
module sssc_top
   import sssc_pkg::*;
#(
   parameter int N_DEV = 8,
   parameter int N_RES = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [N_DEV-1:0] devWakeEvent,
   input wire logic [N_DEV-1:0] devCanWake,
   input wire logic [N_DEV-1:0] devNeedsShallow,
   input wire logic [N_RES-1:0] resLevelS1,
   input wire logic [N_RES-1:0] resLevelS2,
   output logic [N_RES-1:0] resOn,
   output logic [N_DEV-1:0] devForceOff,
   output logic cpuRun,
   output logic cpuBootReset,
   output logic memRetain,
   output logic [1:0] sysState,
   output logic irq
);
   sssc_state_t state_reg;
   logic [SSSC_TYPE_W-1:0] priType_reg;
   logic [SSSC_TYPE_W-1:0] secType_reg;
   logic [SSSC_TYPE_W-1:0] target_reg;
   logic priWake_reg;
   logic secWake_reg;
   logic [15:0] descS0_reg;
   logic [15:0] descS1_reg;
   logic [15:0] descS2_reg;
   logic [N_DEV-1:0] wakeEn_reg;
   logic [SSSC_IRQ_W-1:0] irqSts_reg;
   logic [SSSC_IRQ_W-1:0] irqEn_reg;
   logic [15:0] settle_reg;
   logic bootPend_reg;
   // reads take one wait state so registered data stands at the ready edge
   logic rdWait_reg;
   logic [N_DEV-1:0] wakeSync;
   logic wr;
   logic rd;
   logic hit;
   logic priEnWr;
   logic secEnWr;
   logic wakeHit;
   logic enterEv;
   logic wakeEv;
   logic asleep;

   initial begin
      if (N_DEV < 1 || N_DEV > 32) $error("sssc_top: N_DEV must be 1..32");
      if (N_RES < 1) $error("sssc_top: N_RES must be at least 1");
   end

   sssc_sync #(.WIDTH(N_DEV)) u_wake_sync (
      .core_clk(core_clk),
      .rst(rst),
      .asyncIn(devWakeEvent),
      .syncOut(wakeSync)
   );

   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = !rd || rdWait_reg;
   assign pslverr = (psel && penable) ? !hit : 1'b0;
   assign priEnWr = wr && paddr == SSSC_PRI_CTRL_OFF && pwdata[SSSC_ENABLE_BIT];
   assign secEnWr = wr && paddr == SSSC_SEC_CTRL_OFF && pwdata[SSSC_ENABLE_BIT];
   assign asleep = state_reg == SSSC_SLEEP1 || state_reg == SSSC_SLEEP2;
   // only devices armed by software and able to wake in their state count
   assign wakeHit = |(wakeSync & wakeEn_reg & devCanWake);
   assign wakeEv = asleep && wakeHit;
   assign enterEv = state_reg == SSSC_WORK && secEnWr;

   always_comb begin
      case (paddr)
         SSSC_PRI_CTRL_OFF, SSSC_SEC_CTRL_OFF, SSSC_PRI_STS_OFF, SSSC_SEC_STS_OFF,
         SSSC_STATE_OFF, SSSC_DESC_S0_OFF, SSSC_DESC_S1_OFF, SSSC_DESC_S2_OFF,
         SSSC_WAKE_EN_OFF, SSSC_IRQ_STS_OFF, SSSC_IRQ_EN_OFF, SSSC_IRQ_CLR_OFF: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // type fields store on any write; enable bit is never stored
   always_ff @(posedge core_clk) begin
      if (rst) begin
         priType_reg <= SSSC_CODE_S0;
         secType_reg <= SSSC_CODE_S0;
      end else if (wr && paddr == SSSC_PRI_CTRL_OFF) begin
         priType_reg <= pwdata[SSSC_TYPE_LSB +: SSSC_TYPE_W];
      end else if (wr && paddr == SSSC_SEC_CTRL_OFF) begin
         secType_reg <= pwdata[SSSC_TYPE_LSB +: SSSC_TYPE_W];
      end
   end

   // descriptors: low two bytes hold codes, upper bytes reserved
   always_ff @(posedge core_clk) begin
      if (rst) begin
         descS0_reg <= {5'h00, SSSC_CODE_S0, 5'h00, SSSC_CODE_S0};
         descS1_reg <= {5'h00, SSSC_CODE_S1, 5'h00, SSSC_CODE_S1};
         descS2_reg <= {5'h00, SSSC_CODE_S2, 5'h00, SSSC_CODE_S2};
      end else if (wr) begin
         if (paddr == SSSC_DESC_S0_OFF) descS0_reg <= pwdata[15:0];
         if (paddr == SSSC_DESC_S1_OFF) descS1_reg <= pwdata[15:0];
         if (paddr == SSSC_DESC_S2_OFF) descS2_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wakeEn_reg <= '0;
         irqEn_reg <= '0;
      end else if (wr) begin
         if (paddr == SSSC_WAKE_EN_OFF) wakeEn_reg <= pwdata[N_DEV-1:0];
         if (paddr == SSSC_IRQ_EN_OFF) irqEn_reg <= pwdata[SSSC_IRQ_W-1:0];
      end
   end

   // set wins over a simultaneous write-one clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         priWake_reg <= 1'b0;
         secWake_reg <= 1'b0;
      end else begin
         if (wakeEv) begin
            priWake_reg <= 1'b1;
         end else if (wr && paddr == SSSC_PRI_STS_OFF && pwdata[SSSC_WAKE_BIT]) begin
            priWake_reg <= 1'b0;
         end
         if (wakeEv) begin
            secWake_reg <= 1'b1;
         end else if (wr && paddr == SSSC_SEC_STS_OFF && pwdata[SSSC_WAKE_BIT]) begin
            secWake_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irqSts_reg <= '0;
      end else begin
         for (int b = 0; b < SSSC_IRQ_W; b++) begin
            if ((b == SSSC_IRQ_ENTER_BIT && enterEv) || (b == SSSC_IRQ_WAKE_BIT && wakeEv)) begin
               irqSts_reg[b] <= 1'b1;
            end else if (wr && paddr == SSSC_IRQ_CLR_OFF && pwdata[b]) begin
               irqSts_reg[b] <= 1'b0;
            end
         end
      end
   end
   assign irq = |(irqSts_reg & irqEn_reg);

   // sequencing starts on the secondary enable write, since software writes it last
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_reg <= SSSC_WORK;
         target_reg <= SSSC_CODE_S0;
         settle_reg <= '0;
         bootPend_reg <= 1'b0;
      end else begin
         case (state_reg)
            SSSC_WORK: begin
               // no other path leaves the working state
               if (secEnWr && priType_reg != SSSC_CODE_S0) begin
                  target_reg <= priType_reg;
                  settle_reg <= 16'(SSSC_SETTLE_CYC);
                  state_reg <= SSSC_ENTER;
               end
            end
            SSSC_ENTER: begin
               if (settle_reg > 16'h0001) begin
                  settle_reg <= settle_reg - 16'h0001;
               end else if (target_reg == SSSC_CODE_S1) begin
                  state_reg <= SSSC_SLEEP1;
               end else if (target_reg == SSSC_CODE_S2) begin
                  state_reg <= SSSC_SLEEP2;
               end else begin
                  // unsupported code: abandon quietly, no wake flag
                  state_reg <= SSSC_WORK;
               end
            end
            SSSC_SLEEP1, SSSC_SLEEP2: begin
               if (wakeHit) begin
                  bootPend_reg <= state_reg == SSSC_SLEEP2;
                  settle_reg <= 16'(SSSC_SETTLE_CYC);
                  state_reg <= SSSC_EXIT;
               end
            end
            SSSC_EXIT: begin
               if (settle_reg > 16'h0001) begin
                  settle_reg <= settle_reg - 16'h0001;
               end else begin
                  bootPend_reg <= 1'b0;
                  state_reg <= SSSC_WORK;
               end
            end
            default: state_reg <= SSSC_WORK;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         resOn <= '1;
         devForceOff <= '0;
         cpuRun <= 1'b1;
         cpuBootReset <= 1'b0;
         memRetain <= 1'b1;
         sysState <= 2'h0;
      end else begin
         memRetain <= 1'b1;
         // processor halted while sequencing; context kept in shallow sleep
         cpuRun <= state_reg == SSSC_WORK;
         cpuBootReset <= state_reg == SSSC_SLEEP2 || (state_reg == SSSC_EXIT && bootPend_reg);
         case (state_reg)
            SSSC_SLEEP1: begin
               resOn <= resLevelS1;
               devForceOff <= devNeedsShallow;
               sysState <= 2'h1;
            end
            SSSC_SLEEP2: begin
               resOn <= resLevelS2;
               devForceOff <= '1;
               sysState <= 2'h2;
            end
            default: begin
               resOn <= '1;
               devForceOff <= '0;
               sysState <= 2'h0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdWait_reg <= 1'b0;
      end else begin
         rdWait_reg <= rd && !rdWait_reg;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         prdata <= '0;
      end else if (rd && !rdWait_reg) begin
         prdata <= '0;
         case (paddr)
            SSSC_PRI_CTRL_OFF: prdata[SSSC_TYPE_LSB +: SSSC_TYPE_W] <= priType_reg;
            SSSC_SEC_CTRL_OFF: prdata[SSSC_TYPE_LSB +: SSSC_TYPE_W] <= secType_reg;
            SSSC_PRI_STS_OFF: prdata[SSSC_WAKE_BIT] <= priWake_reg;
            SSSC_SEC_STS_OFF: prdata[SSSC_WAKE_BIT] <= secWake_reg;
            SSSC_STATE_OFF: prdata[2:0] <= state_reg;
            SSSC_DESC_S0_OFF: prdata[15:0] <= descS0_reg;
            SSSC_DESC_S1_OFF: prdata[15:0] <= descS1_reg;
            SSSC_DESC_S2_OFF: prdata[15:0] <= descS2_reg;
            SSSC_WAKE_EN_OFF: prdata[N_DEV-1:0] <= wakeEn_reg;
            SSSC_IRQ_STS_OFF: prdata[SSSC_IRQ_W-1:0] <= irqSts_reg;
            SSSC_IRQ_EN_OFF: prdata[SSSC_IRQ_W-1:0] <= irqEn_reg;
            default: prdata <= '0;
         endcase
      end
   end
endmodule : sssc_top

//--- test/sssc_tb_top.sv
`timescale 1ns/1ps
module system_sleep_state_control_tb_top;
   import sssc_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] devWakeEvent = 8'h00;
   logic [7:0] devCanWake = 8'h00;
   logic [7:0] devNeedsShallow = 8'h00;
   logic [7:0] resLevelS1 = 8'h00;
   logic [7:0] resLevelS2 = 8'h00;
   logic [7:0] resOn;
   logic [7:0] devForceOff;
   logic cpuRun;
   logic cpuBootReset;
   logic memRetain;
   logic irq;
   logic [1:0] sysState;
   int errCount = 0;
   int checksDone = 0;
   int unsigned seed = 61;
   logic [31:0] rd;
   int n;
   int k;
   initial forever #25 core_clk = ~core_clk;
   sssc_top i_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .devWakeEvent(devWakeEvent), .devCanWake(devCanWake),
      .devNeedsShallow(devNeedsShallow), .resLevelS1(resLevelS1), .resLevelS2(resLevelS2),
      .resOn(resOn), .devForceOff(devForceOff), .cpuRun(cpuRun), .cpuBootReset(cpuBootReset),
      .memRetain(memRetain), .sysState(sysState), .irq(irq));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errCount++;
         $display("wrong value %s exp %h got %h", name, exp, got);
      end
   endtask : chk
   // read data is taken at the edge where pready is seen high
   task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask : apb
   task automatic waitState(logic [1:0] s, int maxc);
      n = 0;
      while (sysState !== s && n < maxc) begin
         @(posedge core_clk);
         n++;
      end
   endtask : waitState
   task automatic endSim();
      $display("checks %0d mismatches %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : endSim
   initial begin
      #(50 * 20000);
      errCount++;
      endSim();
   end
   initial begin
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      chk("rstOuts", {cpuRun, cpuBootReset, memRetain, sysState, resOn, devForceOff},
         {1'b1, 1'b0, 1'b1, 2'd0, 8'hFF, 8'h00});
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, SSSC_DESC_S0_OFF + 8'(4 * i), 32'h0);
         chk("desc", rd, {16'h0, 8'(i), 8'(i)});
      end
      apb(1'b1, SSSC_DESC_S2_OFF, 32'hFFFFFFFF);
      apb(1'b0, SSSC_DESC_S2_OFF, 32'h0);
      chk("descRsvd", rd, 32'h0000FFFF);
      apb(1'b1, SSSC_DESC_S2_OFF, 32'h00000202);
      apb(1'b1, 8'h30, 32'hFFFFFFFF);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped", rd, 32'h0);
      apb(1'b1, SSSC_PRI_CTRL_OFF, 32'h400);
      apb(1'b1, SSSC_SEC_CTRL_OFF, 32'h400);
      repeat (30) @(posedge core_clk);
      chk("noCmd", sysState, 32'h0);
      apb(1'b0, SSSC_PRI_CTRL_OFF, 32'h0);
      chk("typeHold", rd, 32'h400);
      apb(1'b1, SSSC_IRQ_EN_OFF, 32'h3);
      apb(1'b1, SSSC_WAKE_EN_OFF, 32'hFF);
      for (int c = 1; c < 4; c++) begin
         resLevelS1 <= xs();
         resLevelS2 <= xs();
         devNeedsShallow <= xs();
         k = xs() % 8;
         apb(1'b1, SSSC_PRI_CTRL_OFF, 32'(c) << 10);
         apb(1'b1, SSSC_SEC_CTRL_OFF, (32'(c) << 10) | 32'h2000);
         waitState((c == 3) ? 2'd0 : 2'(c), 60);
         if (c == 3) repeat (30) @(posedge core_clk);
         chk("sleepState", sysState, (c == 3) ? 0 : c);
         chk("entryLen", (c == 3) || (n > 18 && n < 25), 1'b1);
         chk("irqEnter", irq, 1'b1);
         apb(1'b1, SSSC_IRQ_CLR_OFF, 32'h1);
         chk("irqClr", irq, 1'b0);
         if (c < 3) begin
            chk("sleepOuts", {cpuRun, cpuBootReset, resOn, devForceOff}, {1'b0, c == 2,
               (c == 1) ? resLevelS1 : resLevelS2,
               (c == 1) ? devNeedsShallow : 8'hFF});
            devWakeEvent[k] <= 1'b1;
            repeat (40) @(posedge core_clk);
            chk("noWaker", sysState, c);
            devCanWake[k] <= 1'b1;
            waitState(2'd0, 80);
            repeat (25) @(posedge core_clk);
            chk("wakeOuts", {cpuRun, cpuBootReset, resOn, devForceOff},
               {1'b1, 1'b0, 8'hFF, 8'h00});
            devWakeEvent <= 8'h00;
            devCanWake <= 8'h00;
         end
         apb(1'b0, SSSC_PRI_STS_OFF, 32'h0);
         chk("priWake", rd, (c < 3) ? 32'h8000 : 32'h0);
         apb(1'b0, SSSC_SEC_STS_OFF, 32'h0);
         chk("secWake", rd, (c < 3) ? 32'h8000 : 32'h0);
         chk("irqWake", irq, c < 3);
         apb(1'b1, SSSC_IRQ_EN_OFF, 32'h1);
         chk("irqMask", irq, 1'b0);
         apb(1'b1, SSSC_IRQ_EN_OFF, 32'h3);
         apb(1'b1, SSSC_IRQ_CLR_OFF, 32'h2);
         chk("irqClrW", irq, 1'b0);
         apb(1'b1, SSSC_PRI_STS_OFF, 32'h0);
         apb(1'b0, SSSC_PRI_STS_OFF, 32'h0);
         chk("w0Keep", rd, (c < 3) ? 32'h8000 : 32'h0);
         apb(1'b1, SSSC_PRI_STS_OFF, 32'h8000);
         apb(1'b1, SSSC_SEC_STS_OFF, 32'h8000);
         apb(1'b0, SSSC_PRI_STS_OFF, 32'h0);
         chk("w1Clr", rd, 32'h0);
         apb(1'b0, SSSC_SEC_CTRL_OFF, 32'h0);
         chk("typeKeep", rd, 32'(c) << 10);
         $display("sleep test %0d done", c);
      end
      endSim();
   end
endmodule : system_sleep_state_control_tb_top

//--- test/sssc_top_chk.sv
`timescale 1ns/1ps
module sssc_top_chk
   import sssc_pkg::*;
#(
   parameter int N_DEV = 8,
   parameter int N_RES = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic [N_DEV-1:0] devNeedsShallow,
   input wire logic [N_RES-1:0] resLevelS1,
   input wire logic [N_RES-1:0] resLevelS2,
   input wire logic [N_RES-1:0] resOn,
   input wire logic [N_DEV-1:0] devForceOff,
   input wire logic cpuRun,
   input wire logic cpuBootReset,
   input wire logic memRetain,
   input wire logic [1:0] sysState
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic pendCmd;
   // a command stays pending until the state leaves working
   always_ff @(posedge core_clk) begin
      if (rst || sysState != 2'd0) begin
         pendCmd <= 1'b0;
      end else if (psel && penable && pwrite && paddr == SSSC_SEC_CTRL_OFF
            && pwdata[SSSC_ENABLE_BIT]) begin
         pendCmd <= 1'b1;
      end
   end
   sequence s_entry;
      sysState == 2'd0 ##1 sysState != 2'd0;
   endsequence
   property p_cmd; s_entry |-> pendCmd; endproperty
   property p_mem; memRetain == 1'b1; endproperty
   property p_resS1; sysState == 2'd1 |-> resOn == $past(resLevelS1); endproperty
   property p_resS2; sysState == 2'd2 |-> resOn == $past(resLevelS2); endproperty
   property p_devS1; sysState == 2'd1 |-> devForceOff == $past(devNeedsShallow); endproperty
   property p_devS2; sysState == 2'd2 |-> &devForceOff; endproperty
   property p_cpu; cpuRun |-> sysState == 2'd0; endproperty
   property p_ctx; sysState == 2'd1 |-> !cpuBootReset; endproperty
   property p_boot; sysState == 2'd2 |-> cpuBootReset; endproperty
   property p_err; psel && penable && paddr > SSSC_IRQ_CLR_OFF |-> pslverr; endproperty
   a_cmd: assert property (p_cmd) else $error("sleep without command");
   a_mem: assert property (p_mem) else $error("memory not retained");
   a_resS1: assert property (p_resS1) else $error("shallow resources");
   a_resS2: assert property (p_resS2) else $error("deep resources");
   a_devS1: assert property (p_devS1) else $error("shallow devices");
   a_devS2: assert property (p_devS2) else $error("deep devices");
   a_cpu: assert property (p_cpu) else $error("cpu runs asleep");
   a_ctx: assert property (p_ctx) else $error("shallow boot reset");
   a_boot: assert property (p_boot) else $error("deep no boot");
   a_err: assert property (p_err) else $error("unmapped no error");
endmodule : sssc_top_chk
bind sssc_top sssc_top_chk #(.N_DEV(N_DEV), .N_RES(N_RES)) i_chk (.core_clk(core_clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pslverr(pslverr), .devNeedsShallow(devNeedsShallow),
   .resLevelS1(resLevelS1), .resLevelS2(resLevelS2), .resOn(resOn),
   .devForceOff(devForceOff), .cpuRun(cpuRun), .cpuBootReset(cpuBootReset),
   .memRetain(memRetain), .sysState(sysState));
